//--- include/sctc_map.vh
// register map, field positions, reset values and sizes of the client sdo control
`ifndef SCTC_MAP_VH
`define SCTC_MAP_VH

// register offsets (byte addresses, one 32-bit word each)
`define SCTC_OFF_CTRL      8'h00
`define SCTC_OFF_TXDATA    8'h04
`define SCTC_OFF_STATUS    8'h08
`define SCTC_OFF_RXDATA    8'h0c
`define SCTC_OFF_INTF      8'h10
`define SCTC_OFF_INTE      8'h14

// control register fields
`define SCTC_CTRL_W        5
`define SCTC_CTRL_TXR      0
`define SCTC_CTRL_SELPOL   1
`define SCTC_CTRL_SELFRC   2
`define SCTC_CTRL_PINDIR   3
`define SCTC_CTRL_PINLAT   4
`define SCTC_CTRL_RST      5'h0a

// status register fields
`define SCTC_STAT_EMPTY    0
`define SCTC_STAT_FULL     1
`define SCTC_STAT_SEL      2
`define SCTC_STAT_CNT_LSB  4

// interrupt flag and mask fields
`define SCTC_INT_W         4
`define SCTC_INT_UNDERFLOW 0
`define SCTC_INT_RXBYTE    1
`define SCTC_INT_OVERFLOW  2
`define SCTC_INT_SELSTART  3
`define SCTC_INT_RST       4'h0

// data path sizes
`define SCTC_DATA_W        8
`define SCTC_FIFO_DEPTH    4
`define SCTC_BIT_CNT_W     3

`endif

//--- verilog/sctc_fifo.v
// transmit fifo of the client sdo control: head peek, pop and occupancy count
`timescale 1ns/10ps
module sctc_fifo
#(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
)
(
  input  wire             clock_i,
  input  wire             rstn_i,
  input  wire             ce_i,
  input  wire             push_valid_i,
  output wire             push_ready_o,
  input  wire [WIDTH-1:0] push_data_i,
  input  wire             pop_i,
  output wire [WIDTH-1:0] head_o,
  output wire             empty_o,
  output wire             full_o,
  output wire [AW:0]      count_o
);

  reg  [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_r;
  reg  [AW-1:0]    rd_ptr_r;
  reg  [AW:0]      count_r;
  wire             do_push;
  wire             do_pop;

  assign full_o       = (count_r == DEPTH[AW:0]);
  assign empty_o      = (count_r == {(AW+1){1'b0}});
  assign push_ready_o = ~full_o;
  assign head_o       = mem_r[rd_ptr_r];
  assign count_o      = count_r;
  assign do_push      = push_valid_i & ~full_o;
  // a pop on empty is dropped so the count can never wrap below zero
  assign do_pop       = pop_i & ~empty_o;

  always @(posedge clock_i)
  begin
    if (ce_i && do_push)
    begin
      mem_r[wr_ptr_r] <= push_data_i;
    end
  end

  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end
    else if (ce_i)
    begin
      if (do_push)
      begin
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule // sctc_fifo

//--- verilog/sctc_top.v
// client-mode serial data output control with transmit fifo and register port
//
// Overview of operation
// - sdo state from direction, txr, select, fifo-empty
// - direction 0, inactive: drive output latch level
// - direction 0: pin always driven
// - direction 1: drive only with txr and select
// - active data chosen by txr and fifo fill
// - txr, select, data: send oldest, pop it
// - txr, select, empty: send last received byte, flag underflow
// - no txr, direction 0, data: peek, keep
// - no txr, direction 0, empty: send last received byte, no underflow
// - direction 1, no txr: pin carries nothing
// - select polarity bit: low-active when set
// - select force makes select always active
`timescale 1ns/10ps
`include "sctc_map.vh"
module sctc_top
#(
  parameter DATA_W     = `SCTC_DATA_W,
  parameter FIFO_DEPTH = `SCTC_FIFO_DEPTH,
  parameter FIFO_AW    = 2
)
(
  input  wire        clock_i,
  input  wire        rstn_i,
  input  wire        ce_i,
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output wire [31:0] rdata_o,
  input  wire        sck_i,
  input  wire        ss_i,
  input  wire        sdi_i,
  output wire        sdo_o,
  output wire        sdo_oe_o,
  output wire        irq_o
);

  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // control and interrupt state
  reg  [`SCTC_CTRL_W-1:0] ctrl_r;
  reg  [`SCTC_INT_W-1:0]  intf_r;
  reg  [`SCTC_INT_W-1:0]  intf_nxt;
  reg  [`SCTC_INT_W-1:0]  inte_r;
  reg  [31:0]             rdata_r;
  reg  [31:0]             rdata_nxt;

  // pin synchronisers: stage 1 feeds stage 2 only
  reg                     sck_s1_r;
  reg                     sck_s2_r;
  reg                     sck_s3_r;
  reg                     ss_s1_r;
  reg                     ss_s2_r;
  reg                     sdi_s1_r;
  reg                     sdi_s2_r;

  // shift engine
  reg  [DATA_W-1:0]       tx_shift_r;
  reg  [DATA_W-1:0]       rx_shift_r;
  reg  [DATA_W-1:0]       rx_last_r;
  reg  [`SCTC_BIT_CNT_W-1:0] bit_cnt_r;
  reg                     loaded_r;
  reg                     sel_prev_r;
  reg                     sdo_r;
  reg                     sdo_oe_r;
  reg                     sdo_nxt;
  reg                     sdo_oe_nxt;

  wire                    transmit_data_required;
  wire                    sel_pol;
  wire                    sel_force;
  wire                    pin_dir;
  wire                    pin_lat;
  wire                    sel_act;
  wire                    sck_rise;
  wire                    sck_fall;
  wire                    slot_end;
  wire                    load_evt;
  wire                    byte_done;
  wire                    fifo_push;
  wire                    fifo_ready;
  wire                    fifo_pop;
  wire [DATA_W-1:0]       fifo_head;
  wire                    fifo_empty;
  wire                    fifo_full;
  wire [FIFO_AW:0]        fifo_cnt;
  wire [`SCTC_INT_W-1:0]  evt;
  wire [31:0]             status_word;

  assign transmit_data_required       = ctrl_r[`SCTC_CTRL_TXR];
  assign sel_pol   = ctrl_r[`SCTC_CTRL_SELPOL];
  assign sel_force = ctrl_r[`SCTC_CTRL_SELFRC];
  assign pin_dir   = ctrl_r[`SCTC_CTRL_PINDIR];
  assign pin_lat   = ctrl_r[`SCTC_CTRL_PINLAT];

  // effective select after polarity and force
  assign sel_act = sel_force | (sel_pol ? ~ss_s2_r : ss_s2_r);

  assign sck_rise = sel_act & loaded_r & sck_s2_r & ~sck_s3_r;
  assign sck_fall = sel_act & loaded_r & ~sck_s2_r & sck_s3_r;

  // a byte is chosen once per byte slot, before its first sck edge
  // the eighth fall loads the next byte at once: a separate reload cycle
  // would put its first bit on the pin after the host's next rising edge
  assign slot_end  = sck_fall & (bit_cnt_r == {`SCTC_BIT_CNT_W{1'b0}});
  assign load_evt  = sel_act & (~loaded_r | slot_end);
  assign byte_done = sck_rise & (bit_cnt_r == {`SCTC_BIT_CNT_W{1'b1}});

  // only a txr slot with data consumes the head; with txr clear it is a peek
  assign fifo_pop  = load_evt & transmit_data_required & ~fifo_empty;

  assign fifo_push = ce_i & wr_i & hit(addr_i, `SCTC_OFF_TXDATA);

  assign evt[`SCTC_INT_UNDERFLOW] = load_evt & transmit_data_required & fifo_empty;
  assign evt[`SCTC_INT_RXBYTE]    = byte_done;
  assign evt[`SCTC_INT_OVERFLOW]  = fifo_push & ~fifo_ready;
  assign evt[`SCTC_INT_SELSTART]  = sel_act & ~sel_prev_r;

  assign status_word = {{(32-`SCTC_STAT_CNT_LSB-FIFO_AW-1){1'b0}},
                        fifo_cnt,
                        1'b0,
                        sel_act,
                        fifo_full,
                        fifo_empty};

  sctc_fifo
  #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  )
  u_fifo
  (
    .clock_i      (clock_i),
    .rstn_i       (rstn_i),
    .ce_i         (ce_i),
    .push_valid_i (fifo_push),
    .push_ready_o (fifo_ready),
    .push_data_i  (wdata_i[DATA_W-1:0]),
    .pop_i        (fifo_pop),
    .head_o       (fifo_head),
    .empty_o      (fifo_empty),
    .full_o       (fifo_full),
    .count_o      (fifo_cnt)
  );

  // two-stage capture of the host pins, third sck stage for edge finding
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_s3_r <= 1'b0;
      ss_s1_r  <= 1'b1;
      ss_s2_r  <= 1'b1;
      sdi_s1_r <= 1'b0;
      sdi_s2_r <= 1'b0;
    end
    else if (ce_i)
    begin
      sck_s1_r <= sck_i;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      ss_s1_r  <= ss_i;
      ss_s2_r  <= ss_s1_r;
      sdi_s1_r <= sdi_i;
      sdi_s2_r <= sdi_s1_r;
    end
  end

  // control and mask registers
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ctrl_r <= `SCTC_CTRL_RST;
      inte_r <= `SCTC_INT_RST;
    end
    else if (ce_i && wr_i)
    begin
      if (hit(addr_i, `SCTC_OFF_CTRL))
      begin
        ctrl_r <= wdata_i[`SCTC_CTRL_W-1:0];
      end
      if (hit(addr_i, `SCTC_OFF_INTE))
      begin
        inte_r <= wdata_i[`SCTC_INT_W-1:0];
      end
    end
  end

  // sticky flags: a new event beats a write-one clear in the same cycle
  always @*
  begin
    intf_nxt = intf_r;
    if (wr_i && hit(addr_i, `SCTC_OFF_INTF))
    begin
      intf_nxt = intf_nxt & ~wdata_i[`SCTC_INT_W-1:0];
    end
    intf_nxt = intf_nxt | evt;
  end

  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      intf_r <= `SCTC_INT_RST;
    end
    else if (ce_i)
    begin
      intf_r <= intf_nxt;
    end
  end

  assign irq_o = |(intf_r & inte_r);

  // read data stands only in the cycle after the strobe
  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    if (rd_i)
    begin
      case (addr_i)
        `SCTC_OFF_CTRL:
          rdata_nxt = {{(32-`SCTC_CTRL_W){1'b0}}, ctrl_r};
        `SCTC_OFF_STATUS:
          rdata_nxt = status_word;
        `SCTC_OFF_RXDATA:
          rdata_nxt = {{(32-DATA_W){1'b0}}, rx_last_r};
        `SCTC_OFF_INTF:
          rdata_nxt = {{(32-`SCTC_INT_W){1'b0}}, intf_r};
        `SCTC_OFF_INTE:
          rdata_nxt = {{(32-`SCTC_INT_W){1'b0}}, inte_r};
        default:
          rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_r <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;

  // shift engine: mode 0 framing, sample on rising sck, change on falling sck
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tx_shift_r <= {DATA_W{1'b0}};
      rx_shift_r <= {DATA_W{1'b0}};
      rx_last_r  <= {DATA_W{1'b0}};
      bit_cnt_r  <= {`SCTC_BIT_CNT_W{1'b0}};
      loaded_r   <= 1'b0;
      sel_prev_r <= 1'b0;
    end
    else if (ce_i)
    begin
      sel_prev_r <= sel_act;
      if (!sel_act)
      begin
        // a dropped select abandons any partial byte
        loaded_r  <= 1'b0;
        bit_cnt_r <= {`SCTC_BIT_CNT_W{1'b0}};
      end
      else if (load_evt)
      begin
        loaded_r <= 1'b1;
        if (fifo_empty)
        begin
          tx_shift_r <= rx_last_r;
        end
        else
        begin
          tx_shift_r <= fifo_head;
        end
      end
      else if (sck_rise)
      begin
        rx_shift_r <= {rx_shift_r[DATA_W-2:0], sdi_s2_r};
        bit_cnt_r  <= bit_cnt_r + 1'b1;
        if (byte_done)
        begin
          rx_last_r <= {rx_shift_r[DATA_W-2:0], sdi_s2_r};
        end
      end
      else if (sck_fall)
      begin
        tx_shift_r <= {tx_shift_r[DATA_W-2:0], 1'b0};
      end
    end
  end

  // pin drive decision from direction, txr, select and shifter
  always @*
  begin
    sdo_nxt    = pin_lat;
    sdo_oe_nxt = 1'b0;
    if (!pin_dir)
    begin
      sdo_oe_nxt = 1'b1;
      if (sel_act)
      begin
        sdo_nxt = tx_shift_r[DATA_W-1];
      end
      else
      begin
        sdo_nxt = pin_lat;
      end
    end
    else
    begin
      // with txr clear the pin stays released whatever the fifo holds
      sdo_oe_nxt = transmit_data_required & sel_act;
      sdo_nxt    = tx_shift_r[DATA_W-1];
    end
  end

  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sdo_r    <= 1'b0;
      sdo_oe_r <= 1'b0;
    end
    else if (ce_i)
    begin
      sdo_r    <= sdo_nxt;
      sdo_oe_r <= sdo_oe_nxt;
    end
  end

  assign sdo_o    = sdo_r;
  assign sdo_oe_o = sdo_oe_r;

endmodule // sctc_top

//--- test/sctc_monitor.sv
// port assertions of the client sdo control
`timescale 1ns/10ps
module sctc_monitor
(
  input wire        clock_i,
  input wire        rstn_i,
  input wire        ce_i,
  input wire [7:0]  addr_i,
  input wire [31:0] wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [31:0] rdata_o,
  input wire        ss_i,
  input wire        sdo_o,
  input wire        sdo_oe_o,
  input wire        irq_o
);
  reg  [4:0] cm_r;
  wire       sel;
  // select as the pin would be judged without the synchroniser delay
  assign sel = cm_r[2] | (cm_r[1] ? ~ss_i : ss_i);
  always @(posedge clock_i or negedge rstn_i)
    if (!rstn_i)
      cm_r <= 5'h0a;
    else if (ce_i && wr_i && addr_i == 8'h00)
      cm_r <= wdata_i[4:0];
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  property p_dir0_drive;
    !cm_r[3] [*3] |-> sdo_oe_o;
  endproperty
  property p_latch;
    (!cm_r[3] && !sel && cm_r == $past(cm_r)) [*6] |-> sdo_o == cm_r[4];
  endproperty
  property p_dir1_idle;
    (cm_r[3] && !cm_r[0]) [*3] |-> !sdo_oe_o;
  endproperty
  property p_dir1_drive;
    (cm_r[3] && cm_r[0] && sel) [*6] |-> sdo_oe_o;
  endproperty
  property p_dir1_quiet;
    (cm_r[3] && !sel) [*6] |-> !sdo_oe_o;
  endproperty
  property p_force;
    (cm_r[2] && cm_r[3] && cm_r[0]) [*5] |-> sdo_oe_o;
  endproperty
  property p_pol_low;
    (cm_r[1] && !cm_r[2] && cm_r[3] && ss_i) [*6] |-> !sdo_oe_o;
  endproperty
  property p_rd_zero;
    !$past(rd_i) |-> rdata_o == 32'h0;
  endproperty
  a_dir0_drive: assert property (p_dir0_drive) else $error("sdo undriven");
  a_latch: assert property (p_latch) else $error("sdo not latch level");
  a_dir1_idle: assert property (p_dir1_idle) else $error("sdo driven without txr");
  a_dir1_drive: assert property (p_dir1_drive) else $error("sdo not driven");
  a_dir1_quiet: assert property (p_dir1_quiet) else $error("sdo driven unselected");
  a_force: assert property (p_force) else $error("forced select ignored");
  a_pol_low: assert property (p_pol_low) else $error("low-active select wrong");
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");
  c_drive: cover property (cm_r[3] && sdo_oe_o);
  c_latch: cover property (!cm_r[3] && !sel && sdo_o);
  c_irq: cover property (irq_o);
endmodule // sctc_monitor

//--- test/sctc_host_model.sv
// spi host model: mode 0, msb first, select polarity chosen by the bench
`timescale 1ns/10ps
module sctc_host_model
(
  input  wire        go_i,
  input  wire [31:0] tx_i,
  input  wire [2:0]  n_i,
  input  wire        act_hi_i,
  input  wire        sdo_i,
  input  wire        sdo_oe_i,
  output reg         sck_o,
  output wire        ss_o,
  output reg         sdi_o,
  output reg         got_o,
  output reg  [7:0]  rx_o,
  output reg         busy_o
);
  reg     on_r;
  integer b;
  wire    line;
  // a released data line floats to its pull-up
  assign line = sdo_oe_i ? sdo_i : 1'b1;
  assign ss_o = on_r ~^ act_hi_i;
  initial
  begin
    {sck_o, sdi_o, got_o, on_r, busy_o} = 5'h0;
    rx_o = 8'h00;
  end
  // clock stands low between frames; the sdi line shows its last bit inverted
  always @(posedge go_i)
  begin
    busy_o = 1'b1;
    #30 on_r = 1'b1;
    #800;
    for (b = 8 * n_i - 1; b >= 0; b = b - 1)
    begin
      sdi_o = tx_i[b];
      #400 sck_o = 1'b1;
      rx_o  = {rx_o[6:0], line};
      got_o = (b % 8 == 0);
      #400 sck_o = 1'b0;
      got_o = 1'b0;
    end
    #400 on_r = 1'b0;
    sdi_o  = ~sdi_o;
    busy_o = 1'b0;
  end
endmodule // sctc_host_model

//--- test/test_sctc_top.sv
// bench: register port, spi host traffic and interrupt of the client sdo control
`timescale 1ns/10ps
module test_sctc_top;
  reg         clock_i, rstn_i, wr, rd, rd_d, go, act_hi, ce;
  reg  [7:0]  addr, c;
  reg  [31:0] wdata, tx, s, r;
  reg  [2:0]  n;
  wire [31:0] rdata;
  wire [7:0]  rx;
  wire        sck, ss, sdi, sdo, sdo_oe, irq, got, busy;
  integer     num_errors, comparisons, k;
  reg  [31:0] exp_rd[$];
  reg  [7:0]  exp_by[$];
  sctc_top u_sctc_top
  (
    .clock_i  (clock_i),
    .rstn_i   (rstn_i),
    .ce_i     (ce),
    .addr_i   (addr),
    .wdata_i  (wdata),
    .wr_i     (wr),
    .rd_i     (rd),
    .rdata_o  (rdata),
    .sck_i    (sck),
    .ss_i     (ss),
    .sdi_i    (sdi),
    .sdo_o    (sdo),
    .sdo_oe_o (sdo_oe),
    .irq_o    (irq)
  );
  sctc_host_model u_sctc_host_model
  (
    .go_i     (go),
    .tx_i     (tx),
    .n_i      (n),
    .act_hi_i (act_hi),
    .sdo_i    (sdo),
    .sdo_oe_i (sdo_oe),
    .sck_o    (sck),
    .ss_o     (ss),
    .sdi_o    (sdi),
    .got_o    (got),
    .rx_o     (rx),
    .busy_o   (busy)
  );
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  function [31:0] xs(input [31:0] v);
    reg [31:0] x;
    begin
      x  = v ^ (v << 13);
      x  = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  task cmp(input [31:0] g, input [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e)
      begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task wr_reg(input [7:0] a, input [31:0] d);
    begin
      @(posedge clock_i);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clock_i);
      wr    <= 1'b0;
    end
  endtask
  task rd_reg(input [7:0] a, input [31:0] e);
    begin
      @(posedge clock_i);
      addr <= a;
      rd   <= 1'b1;
      exp_rd.push_back(e);
      @(posedge clock_i);
      rd   <= 1'b0;
    end
  endtask
  task link(input [31:0] t, input [31:0] e, input [2:0] m);
    begin
      for (k = m - 1; k >= 0; k = k - 1)
        exp_by.push_back(e[8*k +: 8]);
      @(posedge clock_i);
      tx <= t;
      n  <= m;
      go <= 1'b1;
      @(posedge clock_i);
      go <= 1'b0;
      for (k = 0; k < 400 && busy === 1'b1; k = k + 1)
        @(posedge clock_i);
      cmp({31'h0, busy}, 32'h0);
      repeat (6) @(posedge clock_i);
    end
  endtask
  // read data is valid only in the slot after the strobe
  always @(posedge clock_i)
  begin
    if (rd_d)
      cmp(rdata, exp_rd.pop_front());
    rd_d <= rd;
  end
  always @(posedge got)
    cmp({24'h0, rx}, {24'h0, exp_by.pop_front()});
  task end_sim;
    begin
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial
  begin
    #3000000;
    num_errors = num_errors + 1;
    end_sim;
  end
  initial
  begin
    num_errors  = 0;
    comparisons = 0;
    s      = 32'd3551;
    rstn_i = 1'b0;
    {wr, rd, rd_d, go, act_hi} = 5'h0;
    ce     = 1'b1;
    addr   = 8'h00;
    {wdata, tx} = 64'h0;
    n      = 3'h1;
    repeat (20) @(posedge clock_i);
    rstn_i <= 1'b1;
    rd_reg(8'h00, 32'h0a);
    rd_reg(8'h08, 32'h01);
    rd_reg(8'h10, 32'h00);
    rd_reg(8'h1c, 32'h00);
    $display("test reset values done");
    s = xs(s);
    r = xs(s);
    wr_reg(8'h00, 32'h0b);
    wr_reg(8'h04, {24'h0, s[7:0]});
    wr_reg(8'h04, {24'h0, s[15:8]});
    link(r, {8'h0, s[7:0], s[15:8], r[15:8]}, 3);
    rd_reg(8'h08, 32'h01);
    rd_reg(8'h10, 32'h0b);
    rd_reg(8'h0c, {24'h0, r[7:0]});
    wr_reg(8'h10, 32'h0f);
    rd_reg(8'h10, 32'h00);
    $display("test pop and underflow done");
    s = xs(r);
    c = s[7:0];
    wr_reg(8'h00, 32'h12);
    wr_reg(8'h04, {24'h0, c});
    link(s, {16'h0, c, c}, 2);
    rd_reg(8'h08, 32'h10);
    wr_reg(8'h00, 32'h13);
    link(r, {24'h0, c}, 1);
    wr_reg(8'h10, 32'h0f);
    wr_reg(8'h00, 32'h12);
    link(s, {24'h0, r[7:0]}, 1);
    rd_reg(8'h10, 32'h0a);
    $display("test peek and resend done");
    act_hi <= 1'b1;
    wr_reg(8'h00, 32'h0d);
    repeat (8) @(posedge clock_i);
    rd_reg(8'h08, 32'h05);
    wr_reg(8'h00, 32'h09);
    wr_reg(8'h10, 32'h0f);
    s = xs(s);
    wr_reg(8'h04, {24'h0, s[7:0]});
    link(r, {24'h0, s[7:0]}, 1);
    $display("test force and polarity done");
    wr_reg(8'h10, 32'h0f);
    wr_reg(8'h14, 32'h04);
    for (k = 0; k < 5; k = k + 1)
    begin
      s = xs(s);
      wr_reg(8'h04, {24'h0, s[7:0]});
    end
    rd_reg(8'h08, 32'h42);
    #1 cmp({31'h0, irq}, 32'h1);
    wr_reg(8'h14, 32'h00);
    #1 cmp({31'h0, irq}, 32'h0);
    wr_reg(8'h14, 32'h04);
    #1 cmp({31'h0, irq}, 32'h1);
    wr_reg(8'h10, 32'h04);
    #1 cmp({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    wr_reg(8'h00, 32'h08);
    link(r, {24'h0, 8'hff}, 1);
    rd_reg(8'h08, 32'h42);
    rd_reg(8'h10, 32'h0a);
    repeat (2) @(posedge clock_i);
    ce <= 1'b0;
    wr_reg(8'h00, 32'h1f);
    ce <= 1'b1;
    rd_reg(8'h00, 32'h08);
    $display("test release and enable done");
    repeat (4) @(posedge clock_i);
    cmp(exp_by.size() + exp_rd.size(), 0);
    end_sim;
  end
endmodule // test_sctc_top
bind sctc_top sctc_monitor u_sctc_monitor
(
  .clock_i  (clock_i),
  .rstn_i   (rstn_i),
  .ce_i     (ce_i),
  .addr_i   (addr_i),
  .wdata_i  (wdata_i),
  .wr_i     (wr_i),
  .rd_i     (rd_i),
  .rdata_o  (rdata_o),
  .ss_i     (ss_i),
  .sdo_o    (sdo_o),
  .sdo_oe_o (sdo_oe_o),
  .irq_o    (irq_o)
);
